// file: logic/eca_pkg.sv
`default_nettype none
package eca_pkg;
   // Register word and address widths
   localparam int unsigned DATA_W = 16;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned CFG_WORDS = 7;
   localparam int unsigned IDX_W = 3;

   // Register offsets
   localparam logic [7:0] ADDR_KEY = 8'h31;
   localparam logic [7:0] ADDR_STATUS = 8'h32;
   localparam logic [7:0] ADDR_LOC = 8'h33;
   localparam logic [7:0] ADDR_WDATA = 8'h34;
   localparam logic [7:0] ADDR_CTRL = 8'h35;
   localparam logic [7:0] ADDR_RDATA = 8'h36;
   localparam logic [7:0] ADDR_MOTOR = 8'h60;
   localparam logic [7:0] CFG_FIRST = 8'h90;
   localparam logic [7:0] CFG_LAST = 8'h96;

   // Field positions
   localparam int unsigned READY_BIT = 0;
   localparam int unsigned MODE_LSB = 0;
   localparam int unsigned WNR_BIT = 2;
   localparam int unsigned RELOAD_BIT = 8;
   localparam int unsigned SHADOW_BIT = 12;
   localparam int unsigned INHIBIT_BIT = 15;

   // Access mode codes and key
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_SINGLE = 2'h1;
   localparam logic [1:0] MODE_MASS = 2'h2;
   localparam logic [15:0] UNLOCK_KEY = 16'hc0de;
   localparam logic [15:0] RST_WORD = 16'h0000;

   // Store timing: times in ns, counts rounded up to whole cycles
   localparam int unsigned CLK_PERIOD_PS = 5000;
   localparam int unsigned STORE_RD_TIME_NS = 50;
   localparam int unsigned STORE_WR_TIME_NS = 1000;
   localparam int unsigned STORE_RD_CYCLES =
      (STORE_RD_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned STORE_WR_CYCLES =
      (STORE_WR_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   typedef enum logic [0:0] {ST_IDLE, ST_BUSY} eca_state_t;
   typedef enum logic [2:0] {OP_SRD, OP_SWR, OP_MRD, OP_MWR, OP_RELOAD} eca_op_t;

   typedef struct packed {
      logic [15:0] key;
      logic [7:0] loc;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic shadow_sel;
      logic wnr;
      logic [1:0] mode;
      logic inhibit;
      logic [CFG_WORDS-1:0][15:0] shadow;
      eca_state_t st;
      eca_op_t op;
      logic [IDX_W-1:0] lat;
      logic [15:0] cnt;
      logic [15:0] bus_rdata;
   } eca_regs_t;
endpackage
`default_nettype wire

// file: logic/eca_store_access.sv
`timescale 1ns/10ps
`default_nettype none
module eca_store_access
   import eca_pkg::*;
#(
   parameter logic [15:0] RD_CYCLES = 16'(eca_pkg::STORE_RD_CYCLES),
   parameter logic [15:0] WR_CYCLES = 16'(eca_pkg::STORE_WR_CYCLES),
   parameter logic [eca_pkg::CFG_WORDS*16-1:0] STORE_INIT = '0
)
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [eca_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [eca_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [eca_pkg::DATA_W-1:0] reg_rdata,
   output logic store_ready_flag,
   output logic motor_inhibit,
   output logic [eca_pkg::CFG_WORDS*16-1:0] active_config
);
   import eca_pkg::*;

   eca_regs_t r;
   eca_regs_t n;
   // Store contents come up from the init image and survive reset
   logic [CFG_WORDS-1:0][15:0] store_mem = STORE_INIT;
   logic st_wr_one;
   logic st_wr_all;
   logic unlocked;
   logic loc_ok;
   logic [7:0] loc_off;
   logic bus_cfg;
   logic [7:0] bus_off;
   logic [IDX_W-1:0] bus_idx;
   logic ctl_wr;
   logic start_acc;
   logic start_reload;

   // Address decode of the single location and the bus address
   // key gate
   assign unlocked = (r.key == UNLOCK_KEY);
   assign loc_off = r.loc - CFG_FIRST;
   assign loc_ok = (r.loc >= CFG_FIRST) && (r.loc <= CFG_LAST);
   assign bus_off = reg_addr - CFG_FIRST;
   assign bus_idx = bus_off[IDX_W-1:0];
   assign bus_cfg = (reg_addr >= CFG_FIRST) && (reg_addr <= CFG_LAST);
   assign ctl_wr = reg_wr && (reg_addr == ADDR_CTRL);

   // Control writes during a busy store start nothing and keep mode and direction, so an access in flight stays coherent; the shadow select is still taken
   // mode decode
   assign start_acc = ctl_wr && (r.st == ST_IDLE) && unlocked &&
      ((reg_wdata[MODE_LSB+:2] == MODE_MASS) ||
       ((reg_wdata[MODE_LSB+:2] == MODE_SINGLE) && loc_ok));
   assign start_reload = ctl_wr && (r.st == ST_IDLE) && reg_wdata[RELOAD_BIT] && !start_acc;

   // Next-state logic: bus writes, access sequencing, bus read mux
   always_comb
   begin
      n = r;
      st_wr_one = 1'b0;
      st_wr_all = 1'b0;
      if (reg_wr)
      begin
         unique case (reg_addr)
            ADDR_KEY: n.key = reg_wdata;
            ADDR_LOC: n.loc = (r.st == ST_IDLE) ? reg_wdata[7:0] : r.loc;
            ADDR_WDATA: n.wdata = (r.st == ST_IDLE) ? reg_wdata : r.wdata;
            ADDR_CTRL:
            begin
               n.shadow_sel = reg_wdata[SHADOW_BIT];
               if (r.st == ST_IDLE)
               begin
                  n.wnr = reg_wdata[WNR_BIT];
                  n.mode = reg_wdata[MODE_LSB+:2];
               end
            end
            ADDR_MOTOR: n.inhibit = reg_wdata[INHIBIT_BIT];
            default:
            begin
               // Shadow words are host-writable only while unlocked
               if (bus_cfg && unlocked)
                  n.shadow[bus_idx] = reg_wdata;
            end
         endcase
      end
      if (start_acc)
      begin
         n.st = ST_BUSY;
         n.lat = loc_off[IDX_W-1:0];
         if (reg_wdata[MODE_LSB+:2] == MODE_SINGLE)
         begin
            n.op = reg_wdata[WNR_BIT] ? OP_SWR : OP_SRD;
            n.cnt = (reg_wdata[WNR_BIT] ? WR_CYCLES : RD_CYCLES) - 16'h0001;
         end
         else
         begin
            n.op = reg_wdata[WNR_BIT] ? OP_MWR : OP_MRD;
            n.cnt = (reg_wdata[WNR_BIT] ? WR_CYCLES : RD_CYCLES) - 16'h0001;
         end
      end
      else if (start_reload)
      begin
         n.st = ST_BUSY;
         n.op = OP_RELOAD;
         n.cnt = RD_CYCLES - 16'h0001;
      end
      else if (r.st == ST_BUSY)
      begin
         if (r.cnt == 16'h0000)
         begin
            n.st = ST_IDLE;
            unique case (r.op)
               OP_SRD: n.rdata = store_mem[r.lat];
               OP_SWR: st_wr_one = 1'b1;
               OP_MWR: st_wr_all = 1'b1;
               OP_MRD, OP_RELOAD: n.shadow = store_mem;
               default: n.st = ST_IDLE;
            endcase
         end
         else
            n.cnt = r.cnt - 16'h0001;
      end
      // Bus read data, reserved bits zero
      // reserved read zero
      if (reg_rd)
      begin
         n.bus_rdata = RST_WORD;
         unique case (reg_addr)
            ADDR_KEY: n.bus_rdata = r.key;
            ADDR_STATUS: n.bus_rdata[READY_BIT] = (r.st == ST_IDLE);
            ADDR_LOC: n.bus_rdata[7:0] = r.loc;
            ADDR_WDATA: n.bus_rdata = r.wdata;
            ADDR_CTRL:
            begin
               n.bus_rdata[SHADOW_BIT] = r.shadow_sel;
               n.bus_rdata[RELOAD_BIT] = (r.st == ST_BUSY) && (r.op == OP_RELOAD);
               n.bus_rdata[WNR_BIT] = r.wnr;
               n.bus_rdata[MODE_LSB+:2] = r.mode;
            end
            ADDR_RDATA: n.bus_rdata = r.rdata;
            ADDR_MOTOR: n.bus_rdata = RST_WORD;
            default:
            begin
               if (bus_cfg)
                  n.bus_rdata = r.shadow_sel ? r.shadow[bus_idx] : store_mem[bus_idx];
            end
         endcase
      end
   end

   // State register; all control resets to zero, mode to off
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         r <= '0;
      end
      else
      begin
         r <= n;
      end
   end

   // Nonvolatile array: not cleared by reset, as the real store keeps its contents
   always_ff @(posedge sys_clk)
   begin
      if (st_wr_all)
         store_mem <= r.shadow;
      else if (st_wr_one)
         store_mem[r.lat] <= r.wdata;
   end

   // Outputs
   // ready flag
   assign store_ready_flag = (r.st == ST_IDLE);
   assign motor_inhibit = r.inhibit;
   assign reg_rdata = r.bus_rdata;
   assign active_config = r.shadow_sel ? r.shadow : store_mem;

   // Checks
   sequence s_single_done;
      (r.st == ST_BUSY) && (r.cnt == 16'h0000) && (r.op == OP_SRD);
   endsequence
   sequence s_write_done;
      (r.st == ST_BUSY) && (r.cnt == 16'h0000) && (r.op == OP_SWR);
   endsequence

   property p_start_busy;
      @(posedge sys_clk) disable iff (rst) (start_acc || start_reload) |=> !store_ready_flag;
   endproperty
   a_start_busy: assert property (p_start_busy) else $error("store not busy after start");

   // Busy-run counter; a long repetition would be costly to unroll, and this
   // way the length is checked for any store timing, not one setting only
   logic [15:0] busy_len_q;
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         busy_len_q <= 16'h0000;
      end
      else if (store_ready_flag)
      begin
         busy_len_q <= 16'h0000;
      end
      else
      begin
         busy_len_q <= busy_len_q + 16'h0001;
      end
   end

   property p_read_len;
      @(posedge sys_clk) disable iff (rst)
         (store_ready_flag && (busy_len_q != 16'h0000))
         |-> (busy_len_q ==
              (((r.op == OP_SWR) || (r.op == OP_MWR)) ? WR_CYCLES : RD_CYCLES));
   endproperty
   a_read_len: assert property (p_read_len) else $error("busy length wrong");

   property p_locked;
      @(posedge sys_clk) disable iff (rst)
         (ctl_wr && !unlocked && !reg_wdata[RELOAD_BIT] && store_ready_flag) |=> store_ready_flag;
   endproperty
   a_locked: assert property (p_locked) else $error("access started while locked");

   property p_mode_off;
      @(posedge sys_clk) disable iff (rst)
         (ctl_wr && (reg_wdata[MODE_LSB+:2] == MODE_OFF) && !reg_wdata[RELOAD_BIT]
          && store_ready_flag) |=> store_ready_flag;
   endproperty
   a_mode_off: assert property (p_mode_off) else $error("disabled mode started access");

   property p_read_word;
      @(posedge sys_clk) disable iff (rst) s_single_done |=> (r.rdata == $past(store_mem[r.lat]));
   endproperty
   a_read_word: assert property (p_read_word) else $error("read data not from store");

   property p_write_word;
      @(posedge sys_clk) disable iff (rst) s_write_done |=> (store_mem[r.lat] == $past(r.wdata));
   endproperty
   a_write_word: assert property (p_write_word) else $error("store word not written");

   property p_shadow_read;
      @(posedge sys_clk) disable iff (rst)
         (reg_rd && bus_cfg && r.shadow_sel) |=> (reg_rdata == $past(r.shadow[bus_idx]));
   endproperty
   a_shadow_read: assert property (p_shadow_read) else $error("config read not shadow");

   property p_active_src;
      @(posedge sys_clk) disable iff (rst)
         $rose(r.shadow_sel) |-> (active_config == r.shadow);
   endproperty
   a_active_src: assert property (p_active_src) else $error("active config not shadow");

   property p_reload;
      @(posedge sys_clk) disable iff (rst)
         ((r.st == ST_BUSY) && (r.cnt == 16'h0000) && (r.op == OP_RELOAD))
         |=> (r.shadow == $past(store_mem));
   endproperty
   a_reload: assert property (p_reload) else $error("shadow not reloaded");

   property p_inhibit_hidden;
      @(posedge sys_clk) disable iff (rst)
         (reg_rd && (reg_addr == ADDR_MOTOR)) |=> (reg_rdata == RST_WORD);
   endproperty
   a_inhibit_hidden: assert property (p_inhibit_hidden) else $error("inhibit readable");

   // A locked host must not reach the shadow words; idle so no copy lands meanwhile
   property p_locked_shadow;
      @(posedge sys_clk) disable iff (rst)
         (reg_wr && bus_cfg && !unlocked && store_ready_flag) |=> $stable(r.shadow);
   endproperty
   a_locked_shadow: assert property (p_locked_shadow) else $error("locked shadow write");

   // Status reads give the ready flag in bit 0 and zeros elsewhere
   property p_ready_status;
      @(posedge sys_clk) disable iff (rst)
         (reg_rd && (reg_addr == ADDR_STATUS))
         |=> (reg_rdata == {15'h0000, $past(store_ready_flag)});
   endproperty
   a_ready_status: assert property (p_ready_status) else $error("status word wrong");
endmodule
`default_nettype wire

// file: tb/eca_host.sv
`timescale 1ns/10ps
`default_nettype none
module eca_host
   import eca_pkg::*;
(
   input wire logic sys_clk,
   input wire logic [15:0] reg_rdata,
   output logic [7:0] reg_addr,
   output logic [15:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd
);
   // Bus starts idle with both strobes low
   initial
   begin
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   // One write per call; data is inverted on release so a stale word never looks valid
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = (a == ADDR_CTRL) ? (d & 16'h1107) : d;
      reg_wr = 1'b1;
      @(negedge sys_clk);
      reg_wr = 1'b0;
      reg_wdata = ~reg_wdata;
   endtask

   // Read strobe for one cycle; the registered answer is settled one edge later
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask

   task automatic unlock;
      wr(ADDR_KEY, UNLOCK_KEY);
   endtask

   task automatic guard(input logic on);
      wr(ADDR_MOTOR, {on, 15'h0000});
   endtask

   // poll ready before the next access
   task automatic wait_ready(output logic ok);
      logic [15:0] s;
      ok = 1'b0;
      for (int i = 0; i < 20 && !ok; i++)
      begin
         rd(ADDR_STATUS, s);
         ok = (s[READY_BIT] === 1'b1);
      end
   endtask
endmodule
`default_nettype wire

// file: tb/eca_store_access_tb.sv
`timescale 1ns/10ps
`default_nettype none
module eca_store_access_tb;
   import eca_pkg::*;
   localparam logic [111:0] INIT = {16'h1007, 16'h1006, 16'h1005, 16'h1004,
      16'h1003, 16'h1002, 16'h1001};
   logic sys_clk;
   logic rst;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [15:0] reg_rdata;
   logic store_ready_flag;
   logic motor_inhibit;
   logic [111:0] active_config;
   int fail_count;
   int checked;
   logic [15:0] v;
   logic ok;

   // Short store times keep the run brief
   eca_store_access #(.RD_CYCLES(16'h0002), .WR_CYCLES(16'h0003), .STORE_INIT(INIT)) dut_u (
      .sys_clk(sys_clk),
      .rst(rst),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .store_ready_flag(store_ready_flag),
      .motor_inhibit(motor_inhibit),
      .active_config(active_config)
   );

   eca_host host_u (
      .sys_clk(sys_clk),
      .reg_rdata(reg_rdata),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd)
   );

   // Clock at 200 MHz
   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
         begin
            fail_count++;
            $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
         end
   endtask

   task automatic chk1(input logic got, input logic exp);
      checked++;
      if (got !== exp)
         begin
            fail_count++;
            $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
         end
   endtask

   task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
      host_u.rd(a, v);
      chk16(v, exp);
   endtask

   // Control write; a started access must drop ready at once and finish in bounded polls
   task automatic start(input logic [15:0] c, input logic busy);
      host_u.wr(ADDR_CTRL, c);
      chk1(store_ready_flag, !busy);
      if (busy)
         begin
            host_u.wait_ready(ok);
            chk1(ok, 1'b1);
         end
   endtask

   task automatic t_reset;
      rchk(ADDR_STATUS, 16'h0001);
      rchk(ADDR_CTRL, 16'h0000);
      rchk(ADDR_RDATA, 16'h0000);
      rchk(8'h40, 16'h0000);
      chk1(motor_inhibit, 1'b0);
      for (int i = 0; i < 7; i++)
         chk16(active_config[16*i +: 16], INIT[16*i +: 16]);
   endtask

   // Without the key no single access starts and the words stay shut; the shadow view
   // shows whether the locked write slipped through, since the store never takes bus writes
   task automatic t_locked;
      host_u.wr(ADDR_LOC, 16'h0090);
      start(16'h0001, 1'b0);
      host_u.wr(CFG_FIRST, 16'hdead);
      rchk(CFG_FIRST, 16'h1001);
      start(16'h1000, 1'b0);
      rchk(CFG_FIRST, 16'h0000);
      start(16'h0000, 1'b0);
   endtask

   task automatic t_single;
      host_u.unlock();
      host_u.guard(1'b1);
      chk1(motor_inhibit, 1'b1);
      rchk(ADDR_MOTOR, 16'h0000);
      host_u.wr(ADDR_LOC, 16'h0096);
      host_u.wr(ADDR_WDATA, 16'ha5a5);
      start(16'h0005, 1'b1);
      chk16(active_config[111:96], 16'ha5a5);
      host_u.wr(ADDR_LOC, 16'h0090);
      start(16'h0001, 1'b1);
      rchk(ADDR_RDATA, 16'h1001);
      host_u.wr(ADDR_LOC, 16'h0096);
      start(16'h0001, 1'b1);
      rchk(ADDR_RDATA, 16'ha5a5);
      host_u.guard(1'b0);
      chk1(motor_inhibit, 1'b0);
   endtask

   // Disabled, reserved and out-of-range requests leave the store idle
   task automatic t_modes;
      start(16'h0000, 1'b0);
      start(16'h0003, 1'b0);
      host_u.wr(ADDR_LOC, 16'h0097);
      start(16'h0001, 1'b0);
   endtask

   task automatic t_shadow;
      start(16'h0100, 1'b1);
      host_u.wr(8'h91, 16'h1234);
      rchk(8'h91, 16'h1002);
      start(16'h1000, 1'b0);
      rchk(8'h91, 16'h1234);
      rchk(8'h96, 16'ha5a5);
      chk16(active_config[31:16], 16'h1234);
      rchk(ADDR_CTRL, 16'h1000);
      start(16'h1002, 1'b1);
      rchk(8'h91, 16'h1002);
      host_u.wr(8'h92, 16'h5555);
      start(16'h1006, 1'b1);
      start(16'h0000, 1'b0);
      rchk(8'h92, 16'h5555);
      chk16(active_config[47:32], 16'h5555);
   endtask

   task automatic close_out;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Main sequence after a ten-cycle reset
   initial
   begin
      fail_count = 0;
      checked = 0;
      rst = 1'b1;
      repeat (10) @(negedge sys_clk);
      rst = 1'b0;
      t_reset();
      t_locked();
      t_single();
      t_modes();
      t_shadow();
      close_out();
   end

   // Whole run needs well under 1000 cycles; a hang is cut off far beyond that
   initial
   begin
      repeat (5000) @(posedge sys_clk);
      fail_count++;
      close_out();
   end
endmodule
`default_nettype wire
